/* hdl/accel_mode_level_detect.sv */
// mode control, sample sequencing and level detection of the three-axis accelerometer
// ************************************************************
// Overview of operation
// - self-test bit drives electrostatic deflection
// - gain field picks 8g, 2g, 4g byte
// - gain change applies live, no mode change
// - mode field: standby, measure, level, pulse
// - standby stops sampling; registers stay accessible
// - measurement samples continuously, interrupts stay inactive
// - byte output any range, 10-bit only 8g
// - sample rate 125 Hz or 250 Hz
// - ready pin high until axis register read
// - unread sample overwritten sets overrun bit
// - level mode latches interrupt until cleared
// - level detection uses 8g data only
// - control one bits 3-5 disable axes
// - polarity 0: any enabled axis above
// - polarity 1: all enabled axes below
// - sign option picks magnitude or signed compare
// - threshold unsigned 7-bit or signed 8-bit
// - event drives assigned pin, records source
// - bandwidth bit picks 62.5 or 125 Hz
// ************************************************************
`default_nettype none

module accel_mode_level_detect
  import accel_pkg::*;
#(
  parameter int unsigned SLOW_PERIOD_CYC = SAMPLE_SLOW_CYC, // cycles per 125 Hz sample
  parameter int unsigned FAST_PERIOD_CYC = SAMPLE_FAST_CYC  // cycles per 250 Hz sample
)
(
  input  wire logic                    CLOCK_IN,           // 250 MHz clock
  input  wire logic                    RST_N_IN,           // async reset, active low
  input  wire logic                    CE_IN,              // clock enable, freezes state
  input  wire accel_pkg::reg_access_s  REG_ACCESS_IN,      // register request from serial port
  output logic      [7:0]              REG_RDATA_OUT,      // read data, one cycle after rd
  output logic                         CONV_START_OUT,     // one-cycle conversion request
  input  wire logic                    CONV_DONE_IN,       // conversion finished pulse
  input  wire accel_pkg::axis_sample_s ADC_SAMPLE_IN,      // three raw axes, valid with done
  output logic                         CELL_POWER_OUT,     // measurement circuitry on
  output logic                         SELF_TEST_OUT,      // electrostatic deflection on
  output logic                         FILTER_WIDE_OUT,    // 1: 125 Hz bandwidth
  output logic                         THREE_WIRE_OUT,     // serial port three-wire select
  output logic                         OUTPUT_DRIVE_OUT,   // interrupt pin drive option
  output logic                         SAMPLE_READY_OUT,   // data-ready pin
  output logic                         IRQ_PIN_ONE_OUT,    // first interrupt pin
  output logic                         IRQ_PIN_TWO_OUT     // second interrupt pin
);

  import accel_pkg::*;

  typedef enum logic [0:0] {SEQ_IDLE, SEQ_CONVERT} seq_state_e;

  logic [7:0]        mode_control_reg;
  logic [7:0]        detect_ctrl_one_reg;
  logic [7:0]        detect_ctrl_two_reg;
  logic [7:0]        level_threshold_reg;
  logic [7:0]        detect_source_reg;
  logic [7:0]        detect_source_next;
  logic              ready_reg;
  logic              overrun_reg;
  logic              level_flag_reg;
  logic              level_flag_next;
  logic              new_sample_reg;
  axis_sample_s      sample_reg;
  seq_state_e        seq_state_reg;
  logic [SAMPLE_COUNT_WIDTH-1:0] timer_reg;
  logic [SAMPLE_COUNT_WIDTH-1:0] period_cyc;
  logic [7:0]        rdata_next;

  logic [1:0]        mode;
  logic [1:0]        gain;
  logic              running;
  logic              detecting;
  logic              sample_tick;
  logic              store_sample;
  logic              axis_read;
  logic              clear_write;
  logic [2:0]        axis_disable;
  logic [2:0]        above;
  logic [2:0]        below;
  logic [2:0]        above_en;
  logic              level_event;
  logic [RAW_WIDTH-1:0] raw_axis [3];
  logic [7:0]        scaled_axis [3];
  logic [7:0]        detect_axis [3];

  // ************************************************************
  // decode of control fields
  // ************************************************************
  assign mode         = mode_control_reg[MODE_LSB +: 2];
  assign gain         = mode_control_reg[GAIN_LSB +: 2];
  assign running      = (mode != MODE_STANDBY);
  // pulse mode keeps level detection alive; pulse timers are not built here
  assign detecting    = (mode == MODE_LEVEL) || (mode == MODE_PULSE);
  assign axis_disable = detect_ctrl_one_reg[AXIS_X_DISABLE_BIT +: 3];
  assign axis_read    = REG_ACCESS_IN.rd && (REG_ACCESS_IN.addr <= AXIS_Z_BYTE_OFFSET);
  assign clear_write  = REG_ACCESS_IN.wr && (REG_ACCESS_IN.addr == DETECT_CLEAR_OFFSET);
  assign raw_axis[0]  = sample_reg.x;
  assign raw_axis[1]  = sample_reg.y;
  assign raw_axis[2]  = sample_reg.z;

  // ************************************************************
  // per-axis scaling and comparison
  // ************************************************************
  for (genvar i = 0; i < 3; i++)
  begin : g_axis
    axis_scale u_scale (
      .raw_in     (raw_axis[i]),
      .gain_in    (gain),
      .scaled_out (scaled_axis[i]),
      .detect_out (detect_axis[i])
    );
    level_compare u_compare (
      .value_in     (detect_axis[i]),
      .threshold_in (level_threshold_reg),
      .signed_in    (detect_ctrl_one_reg[THRESH_SIGN_BIT]),
      .above_out    (above[i]),
      .below_out    (below[i])
    );
  end

  assign above_en = above & ~axis_disable;

  // with every axis disabled neither condition can fire
  always_comb
  begin
    if (detect_ctrl_two_reg[LEVEL_POLARITY_BIT])
      level_event = (axis_disable != 3'h7) && ((below | axis_disable) == 3'h7);
    else
      level_event = |above_en;
  end

  // ************************************************************
  // register writes
  // ************************************************************
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      mode_control_reg    <= CONTROL_RESET;
      detect_ctrl_one_reg <= CONTROL_RESET;
      detect_ctrl_two_reg <= CONTROL_RESET;
      level_threshold_reg <= CONTROL_RESET;
    end
    else if (CE_IN && REG_ACCESS_IN.wr)
    begin
      unique case (REG_ACCESS_IN.addr)
        MODE_CONTROL_OFFSET:    mode_control_reg <= REG_ACCESS_IN.wdata & MODE_CONTROL_MASK;
        DETECT_CTRL_ONE_OFFSET: detect_ctrl_one_reg <= REG_ACCESS_IN.wdata;
        DETECT_CTRL_TWO_OFFSET:
          detect_ctrl_two_reg <= REG_ACCESS_IN.wdata & DETECT_CTRL_TWO_MASK;
        LEVEL_THRESHOLD_OFFSET: level_threshold_reg <= REG_ACCESS_IN.wdata;
        default: ;
      endcase
    end
  end

  // ************************************************************
  // sample timer and conversion sequencer
  // ************************************************************
  always_comb
  begin
    if (detect_ctrl_one_reg[FILTER_BW_BIT])
      period_cyc = SAMPLE_COUNT_WIDTH'(FAST_PERIOD_CYC - 1);
    else
      period_cyc = SAMPLE_COUNT_WIDTH'(SLOW_PERIOD_CYC - 1);
  end

  assign sample_tick  = running && (timer_reg == '0);
  assign store_sample = (seq_state_reg == SEQ_CONVERT) && CONV_DONE_IN && running;

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      timer_reg <= '0;
    else if (CE_IN)
    begin
      if (!running || sample_tick || timer_reg > period_cyc)
        timer_reg <= period_cyc;
      else
        timer_reg <= timer_reg - 1'b1;
    end
  end

  // a tick that lands while a conversion is still open is dropped
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      seq_state_reg  <= SEQ_IDLE;
      CONV_START_OUT <= 1'b0;
    end
    else if (CE_IN)
    begin
      CONV_START_OUT <= 1'b0;
      unique case (seq_state_reg)
        SEQ_IDLE:
          if (sample_tick)
          begin
            seq_state_reg  <= SEQ_CONVERT;
            CONV_START_OUT <= 1'b1;
          end
        SEQ_CONVERT:
          if (CONV_DONE_IN || !running)
            seq_state_reg <= SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      sample_reg     <= '0;
      new_sample_reg <= 1'b0;
    end
    else if (CE_IN)
    begin
      new_sample_reg <= store_sample;
      if (store_sample)
        sample_reg <= ADC_SAMPLE_IN;
    end
  end

  // ************************************************************
  // data-ready and overrun, set wins over clear
  // ************************************************************
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      ready_reg   <= 1'b0;
      overrun_reg <= 1'b0;
    end
    else if (CE_IN)
    begin
      if (store_sample)
        ready_reg <= 1'b1;
      else if (axis_read)
        ready_reg <= 1'b0;
      if (store_sample && ready_reg)
        overrun_reg <= 1'b1;
      else if (axis_read)
        overrun_reg <= 1'b0;
    end
  end

  // ************************************************************
  // level detection latch and source register
  // ************************************************************
  always_comb
  begin
    level_flag_next    = level_flag_reg;
    detect_source_next = detect_source_reg;
    if (clear_write)
    begin
      level_flag_next    = 1'b0;
      detect_source_next = '0;
    end
    if (new_sample_reg && detecting && level_event)
    begin
      level_flag_next = 1'b1;
      detect_source_next[LEVEL_SOURCE_BIT] = 1'b1;
      detect_source_next[AXIS_X_SOURCE_BIT +: 3] =
        detect_source_next[AXIS_X_SOURCE_BIT +: 3] |
        (detect_ctrl_two_reg[LEVEL_POLARITY_BIT] ? (below & ~axis_disable) : above_en);
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      level_flag_reg    <= 1'b0;
      detect_source_reg <= '0;
    end
    else if (CE_IN)
    begin
      level_flag_reg    <= level_flag_next;
      detect_source_reg <= detect_source_next;
    end
  end

  // ************************************************************
  // register read
  // ************************************************************
  always_comb
  begin
    unique case (REG_ACCESS_IN.addr)
      AXIS_X_LOW_OFFSET:      rdata_next = sample_reg.x[7:0];
      AXIS_X_HIGH_OFFSET:     rdata_next = {{6{sample_reg.x[9]}}, sample_reg.x[9:8]};
      AXIS_Y_LOW_OFFSET:      rdata_next = sample_reg.y[7:0];
      AXIS_Y_HIGH_OFFSET:     rdata_next = {{6{sample_reg.y[9]}}, sample_reg.y[9:8]};
      AXIS_Z_LOW_OFFSET:      rdata_next = sample_reg.z[7:0];
      AXIS_Z_HIGH_OFFSET:     rdata_next = {{6{sample_reg.z[9]}}, sample_reg.z[9:8]};
      AXIS_X_BYTE_OFFSET:     rdata_next = scaled_axis[0];
      AXIS_Y_BYTE_OFFSET:     rdata_next = scaled_axis[1];
      AXIS_Z_BYTE_OFFSET:     rdata_next = scaled_axis[2];
      STATUS_OFFSET:
        rdata_next = {6'h00, overrun_reg, ready_reg};
      DETECT_SOURCE_OFFSET:   rdata_next = detect_source_reg;
      MODE_CONTROL_OFFSET:    rdata_next = mode_control_reg;
      DETECT_CTRL_ONE_OFFSET: rdata_next = detect_ctrl_one_reg;
      DETECT_CTRL_TWO_OFFSET: rdata_next = detect_ctrl_two_reg;
      LEVEL_THRESHOLD_OFFSET: rdata_next = level_threshold_reg;
      default:                rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      REG_RDATA_OUT <= 8'h00;
    else if (CE_IN && REG_ACCESS_IN.rd)
      REG_RDATA_OUT <= rdata_next;
  end

  // ************************************************************
  // pins, all registered
  // ************************************************************
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      CELL_POWER_OUT   <= 1'b0;
      SELF_TEST_OUT    <= 1'b0;
      FILTER_WIDE_OUT  <= 1'b0;
      THREE_WIRE_OUT   <= 1'b0;
      OUTPUT_DRIVE_OUT <= 1'b0;
      SAMPLE_READY_OUT <= 1'b0;
      IRQ_PIN_ONE_OUT  <= 1'b0;
      IRQ_PIN_TWO_OUT  <= 1'b0;
    end
    else if (CE_IN)
    begin
      CELL_POWER_OUT   <= running;
      // deflection only while the cell is powered, otherwise it cannot act
      SELF_TEST_OUT    <= running && mode_control_reg[SELF_TEST_BIT];
      FILTER_WIDE_OUT  <= detect_ctrl_one_reg[FILTER_BW_BIT];
      THREE_WIRE_OUT   <= mode_control_reg[THREE_WIRE_BIT];
      OUTPUT_DRIVE_OUT <= detect_ctrl_two_reg[OUTPUT_DRIVE_BIT];
      SAMPLE_READY_OUT <= running && !mode_control_reg[READY_PIN_DIS_BIT]
                          && (ready_reg || store_sample) && !axis_read;
      IRQ_PIN_ONE_OUT  <= level_flag_next && detecting
                          && !detect_ctrl_one_reg[IRQ_PIN_SWAP_BIT];
      IRQ_PIN_TWO_OUT  <= level_flag_next && detecting
                          && detect_ctrl_one_reg[IRQ_PIN_SWAP_BIT];
    end
  end

endmodule

`default_nettype wire

/* hdl/accel_pkg.sv */
// constants, register map and carrier types of the accelerometer control logic
`default_nettype none

package accel_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] AXIS_X_LOW_OFFSET   = 8'h00;
  localparam logic [7:0] AXIS_X_HIGH_OFFSET  = 8'h01;
  localparam logic [7:0] AXIS_Y_LOW_OFFSET   = 8'h02;
  localparam logic [7:0] AXIS_Y_HIGH_OFFSET  = 8'h03;
  localparam logic [7:0] AXIS_Z_LOW_OFFSET   = 8'h04;
  localparam logic [7:0] AXIS_Z_HIGH_OFFSET  = 8'h05;
  localparam logic [7:0] AXIS_X_BYTE_OFFSET  = 8'h06;
  localparam logic [7:0] AXIS_Y_BYTE_OFFSET  = 8'h07;
  localparam logic [7:0] AXIS_Z_BYTE_OFFSET  = 8'h08;
  localparam logic [7:0] STATUS_OFFSET       = 8'h09;
  localparam logic [7:0] DETECT_SOURCE_OFFSET = 8'h0A;
  localparam logic [7:0] MODE_CONTROL_OFFSET = 8'h16;
  localparam logic [7:0] DETECT_CTRL_ONE_OFFSET = 8'h18;
  localparam logic [7:0] DETECT_CTRL_TWO_OFFSET = 8'h19;
  localparam logic [7:0] LEVEL_THRESHOLD_OFFSET = 8'h1A;
  localparam logic [7:0] DETECT_CLEAR_OFFSET = 8'h1F;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int MODE_LSB            = 0;
  localparam int GAIN_LSB            = 2;
  localparam int SELF_TEST_BIT       = 4;
  localparam int THREE_WIRE_BIT      = 5;
  localparam int READY_PIN_DIS_BIT   = 6;
  localparam int IRQ_PIN_SWAP_BIT    = 0;
  localparam int IRQ_ROUTING_LSB     = 1;
  localparam int AXIS_X_DISABLE_BIT  = 3;
  localparam int THRESH_SIGN_BIT     = 6;
  localparam int FILTER_BW_BIT       = 7;
  localparam int LEVEL_POLARITY_BIT  = 0;
  localparam int PULSE_POLARITY_BIT  = 1;
  localparam int OUTPUT_DRIVE_BIT    = 2;
  localparam int READY_STATUS_BIT    = 0;
  localparam int OVERRUN_STATUS_BIT  = 1;
  localparam int LEVEL_SOURCE_BIT    = 0;
  localparam int AXIS_X_SOURCE_BIT   = 3;
  localparam logic [7:0] MODE_CONTROL_MASK    = 8'h7F;
  localparam logic [7:0] DETECT_CTRL_TWO_MASK = 8'h07;
  localparam logic [7:0] CONTROL_RESET        = 8'h00;

  // ************************************************************
  // encodings
  // ************************************************************
  localparam logic [1:0] MODE_STANDBY = 2'h0;
  localparam logic [1:0] MODE_MEASURE = 2'h1;
  localparam logic [1:0] MODE_LEVEL   = 2'h2;
  localparam logic [1:0] MODE_PULSE   = 2'h3;
  localparam logic [1:0] GAIN_8G      = 2'h0;
  localparam logic [1:0] GAIN_2G      = 2'h1;
  localparam logic [1:0] GAIN_4G      = 2'h2;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLOCK_PERIOD_NS      = 4;
  localparam int unsigned SAMPLE_SLOW_NS       = 8_000_000;
  localparam int unsigned SAMPLE_FAST_NS       = 4_000_000;
  localparam int unsigned SAMPLE_SLOW_CYC      = SAMPLE_SLOW_NS / CLOCK_PERIOD_NS;
  localparam int unsigned SAMPLE_FAST_CYC      = SAMPLE_FAST_NS / CLOCK_PERIOD_NS;
  localparam int          SAMPLE_COUNT_WIDTH   = 21;
  localparam int          RAW_WIDTH            = 10;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic [RAW_WIDTH-1:0] z;
    logic [RAW_WIDTH-1:0] y;
    logic [RAW_WIDTH-1:0] x;
  } axis_sample_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_access_s;

endpackage

`default_nettype wire

/* hdl/axis_scale.sv */
// scales one raw axis sample to the selected byte range and to the 8g detection byte
`default_nettype none

module axis_scale
  import accel_pkg::*;
(
  input  wire logic [RAW_WIDTH-1:0] raw_in,    // signed sample, 8g scale, 64 counts/g
  input  wire logic [1:0]           gain_in,   // selected byte range
  output logic      [7:0]           scaled_out, // byte at selected range
  output logic      [7:0]           detect_out  // byte at 8g range
);

  logic signed [RAW_WIDTH-1:0] raw_s;
  logic signed [RAW_WIDTH-1:0] half_s;

  // clips a 10-bit signed value into a signed byte
  function automatic logic [7:0] clip8(input logic signed [RAW_WIDTH-1:0] v);
    logic [7:0] r;
    r = v[7:0];
    if (v > 10'sd127)
      r = 8'h7F;
    else if (v < -10'sd128)
      r = 8'h80;
    return r;
  endfunction

  assign raw_s      = $signed(raw_in);
  assign half_s     = raw_s >>> 1;
  assign detect_out = 8'((raw_s >>> 2));

  // combinational so a range change takes effect on the very next read
  always_comb
  begin
    unique case (gain_in)
      GAIN_2G: scaled_out = clip8(raw_s);
      GAIN_4G: scaled_out = clip8(half_s);
      default: scaled_out = detect_out;
    endcase
  end

endmodule

`default_nettype wire

/* hdl/level_compare.sv */
// compares one axis byte against the level threshold, magnitude or signed
`default_nettype none

module level_compare
(
  input  wire logic [7:0] value_in,     // axis byte at 8g range
  input  wire logic [7:0] threshold_in, // level threshold
  input  wire logic       signed_in,    // 1: signed compare, 0: magnitude
  output logic            above_out,    // value exceeds threshold
  output logic            below_out     // value under threshold
);

  logic [7:0] magnitude;
  logic [7:0] thresh_mag;

  // -128 has magnitude 128, which still fits the unsigned byte
  assign magnitude  = value_in[7] ? 8'(-value_in) : value_in;
  // top bit is ignored in magnitude mode; software keeps it clear
  assign thresh_mag = {1'b0, threshold_in[6:0]};

  always_comb
  begin
    if (signed_in)
    begin
      above_out = $signed(value_in) > $signed(threshold_in);
      below_out = $signed(value_in) < $signed(threshold_in);
    end
    else
    begin
      above_out = magnitude > thresh_mag;
      below_out = magnitude < thresh_mag;
    end
  end

endmodule

`default_nettype wire

/* verif/accel_mode_level_detect_properties.sv */
// port assertions for the accelerometer control logic
`default_nettype none
module accel_mode_level_detect_properties
  import accel_pkg::*;
(
  input wire logic                   CLOCK_IN,         // clock
  input wire logic                   RST_N_IN,         // reset, active low
  input wire logic                   CE_IN,            // clock enable
  input wire accel_pkg::reg_access_s REG_ACCESS_IN,    // register request
  input wire logic                   CONV_START_OUT,   // conversion request
  input wire logic                   CONV_DONE_IN,     // conversion done
  input wire logic                   CELL_POWER_OUT,   // cell power
  input wire logic                   SELF_TEST_OUT,    // deflection on
  input wire logic                   SAMPLE_READY_OUT, // ready pin
  input wire logic                   IRQ_PIN_ONE_OUT,  // interrupt one
  input wire logic                   IRQ_PIN_TWO_OUT   // interrupt two
);
  // ************************************************************
  // shadow of the mode register, taken from writes at the port
  // ************************************************************
  logic [7:0] mode_reg;
  logic       any_irq;
  assign any_irq = IRQ_PIN_ONE_OUT | IRQ_PIN_TWO_OUT;
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
    if (!RST_N_IN)
      mode_reg <= CONTROL_RESET;
    else if (CE_IN && REG_ACCESS_IN.wr && REG_ACCESS_IN.addr == MODE_CONTROL_OFFSET)
      mode_reg <= REG_ACCESS_IN.wdata;

  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_N_IN);

  AST_POWER_MODE: assert property (CELL_POWER_OUT == ($past(mode_reg[1:0]) != MODE_STANDBY))
    else $error("cell power does not follow mode");
  AST_SELF_TEST: assert property (SELF_TEST_OUT == ($past(mode_reg[SELF_TEST_BIT])
    && $past(mode_reg[1:0]) != MODE_STANDBY)) else $error("self test pin wrong");
  AST_NO_START_STBY: assert property ((mode_reg[1:0] == MODE_STANDBY) &&
    ($past(mode_reg[1:0]) == MODE_STANDBY) |-> !CONV_START_OUT) else $error("start in standby");
  AST_START_ONE: assert property (CONV_START_OUT |=> !CONV_START_OUT)
    else $error("start longer than one cycle");
  AST_READY_CAUSE: assert property ($rose(SAMPLE_READY_OUT) |-> $past(CONV_DONE_IN))
    else $error("ready pin rose without a sample");
  AST_READY_CLEAR: assert property (SAMPLE_READY_OUT && REG_ACCESS_IN.rd &&
    REG_ACCESS_IN.addr <= AXIS_Z_BYTE_OFFSET && !CONV_DONE_IN |=> !SAMPLE_READY_OUT)
    else $error("ready pin not cleared by axis read");
  AST_MEASURE_QUIET: assert property ($past(mode_reg[1:0]) == MODE_MEASURE |-> !any_irq)
    else $error("interrupt in measurement mode");
  AST_IRQ_CAUSE: assert property ($rose(any_irq) |-> $past(CONV_DONE_IN) ||
    $past(CONV_DONE_IN, 2) || $past(CONV_DONE_IN, 3) || $past(CONV_DONE_IN, 4))
    else $error("interrupt rose without a sample");
  AST_IRQ_HOLD: assert property (any_irq && !REG_ACCESS_IN.wr &&
    !$past(REG_ACCESS_IN.wr) |=> any_irq) else $error("interrupt latch dropped");
endmodule

bind accel_mode_level_detect accel_mode_level_detect_properties u_props (
  .CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN), .CE_IN(CE_IN), .REG_ACCESS_IN(REG_ACCESS_IN),
  .CONV_START_OUT(CONV_START_OUT), .CONV_DONE_IN(CONV_DONE_IN),
  .CELL_POWER_OUT(CELL_POWER_OUT), .SELF_TEST_OUT(SELF_TEST_OUT),
  .SAMPLE_READY_OUT(SAMPLE_READY_OUT), .IRQ_PIN_ONE_OUT(IRQ_PIN_ONE_OUT),
  .IRQ_PIN_TWO_OUT(IRQ_PIN_TWO_OUT));
`default_nettype wire

/* verif/adc_model.sv */
// behavioural three-axis converter answering conversion requests
`default_nettype none
module adc_model
  import accel_pkg::*;
(
  input  wire logic                    clock_in,   // clock
  input  wire logic                    start_in,   // conversion request
  input  wire logic [3:0]              delay_in,   // answer delay in cycles, 1 is prompt
  input  wire accel_pkg::axis_sample_s accel_in,   // acceleration to report
  output logic                         done_out,   // one-cycle done
  output var accel_pkg::axis_sample_s  sample_out  // valid only with done
);
  int unsigned cnt = 0;
  initial done_out = 1'b0;
  // outside done the bus shows the inverse, so a design sampling late sees garbage
  always @(posedge clock_in)
  begin
    done_out   <= 1'b0;
    sample_out <= ~accel_in;
    if (cnt == 1)
    begin
      done_out   <= 1'b1;
      sample_out <= accel_in;
    end
    if (cnt != 0) cnt = cnt - 1;
    if (start_in) cnt = delay_in;
  end
endmodule
`default_nettype wire

/* verif/tb_accel_mode_level_detect.sv */
// self-checking testbench of the accelerometer control logic
`default_nettype none
module tb_accel_mode_level_detect;
  import accel_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, start, done, power, ready, irq1, irq2, fwide, tw, drv;
  logic [7:0] rdata;
  logic [3:0] delay = 4'h1;
  reg_access_s req = '0;
  axis_sample_s accel = '0, sample;
  int mismatches = 0, compares = 0;
  localparam logic [7:0] RESET_ADDRS [5] = '{8'h16, 8'h18, 8'h19, 8'h1A, 8'h30};

  initial forever #2 clk = ~clk;
  accel_mode_level_detect #(.SLOW_PERIOD_CYC(40), .FAST_PERIOD_CYC(20)) DUT (
    .CLOCK_IN(clk), .RST_N_IN(rst_n), .CE_IN(1'b1), .REG_ACCESS_IN(req), .REG_RDATA_OUT(rdata),
    .CONV_START_OUT(start), .CONV_DONE_IN(done), .ADC_SAMPLE_IN(sample), .CELL_POWER_OUT(power),
    .SELF_TEST_OUT(), .FILTER_WIDE_OUT(fwide), .THREE_WIRE_OUT(tw), .OUTPUT_DRIVE_OUT(drv),
    .SAMPLE_READY_OUT(ready), .IRQ_PIN_ONE_OUT(irq1), .IRQ_PIN_TWO_OUT(irq2));
  adc_model u_adc (.clock_in(clk), .start_in(start), .delay_in(delay), .accel_in(accel),
    .done_out(done), .sample_out(sample));

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{a, d, w, !w};
    @(posedge clk);
    req <= '0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    access(1'b0, a, 8'h00);
    check(rdata, exp);
  endtask
  task automatic wait_sample;
    int n;
    n = 0;
    while (done !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    check(8'(n == 300), 8'h00);
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic period(input int exp);
    time t0;
    repeat (2) @(posedge start);
    t0 = $time;
    @(posedge start);
    check(8'(($time - t0) / 4), 8'(exp));
  endtask
  task automatic level(input logic [7:0] c1, c2, th, input logic [1:0] pins);
    access(1'b1, DETECT_CTRL_ONE_OFFSET, c1);
    access(1'b1, DETECT_CTRL_TWO_OFFSET, c2);
    access(1'b1, LEVEL_THRESHOLD_OFFSET, th);
    access(1'b1, DETECT_CLEAR_OFFSET, 8'h00);
    wait_sample();
    check({6'h00, irq2, irq1}, {6'h00, pins});
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  initial
  begin
    accel = '{z: 10'h3C0, y: 10'h000, x: 10'h064};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    foreach (RESET_ADDRS[i]) rd(RESET_ADDRS[i], 8'h00);
    access(1'b1, DETECT_CTRL_TWO_OFFSET, 8'hFF);
    rd(DETECT_CTRL_TWO_OFFSET, 8'h07);
    access(1'b1, MODE_CONTROL_OFFSET, 8'h01);
    period(40);
    access(1'b1, DETECT_CTRL_ONE_OFFSET, 8'h80);
    period(20);
    check(8'(fwide), 8'h01);
    access(1'b1, DETECT_CTRL_ONE_OFFSET, 8'h00);
    rd(STATUS_OFFSET, 8'h03);
    wait_sample();
    rd(AXIS_X_LOW_OFFSET, 8'h64);
    wait_sample();
    rd(STATUS_OFFSET, 8'h01);
    check(8'(ready), 8'h01);
    delay <= 4'h9;
    wait_sample();
    rd(STATUS_OFFSET, 8'h03);
    rd(AXIS_Z_LOW_OFFSET, 8'hC0);
    check(8'(ready), 8'h00);
    rd(AXIS_Z_HIGH_OFFSET, 8'hFF);
    access(1'b1, MODE_CONTROL_OFFSET, 8'h05);
    rd(AXIS_X_BYTE_OFFSET, 8'h64);
    access(1'b1, MODE_CONTROL_OFFSET, 8'h59);
    rd(AXIS_X_BYTE_OFFSET, 8'h32);
    wait_sample();
    rd(STATUS_OFFSET, 8'h01);
    check(8'(ready), 8'h00);
    access(1'b1, MODE_CONTROL_OFFSET, 8'h30);
    repeat (100) @(posedge clk);
    check({4'h0, fwide, tw, drv, power}, 8'h06);
    rd(AXIS_X_BYTE_OFFSET, 8'h19);
    accel <= '{z: 10'h000, y: 10'h000, x: 10'h39C};
    access(1'b1, MODE_CONTROL_OFFSET, 8'h06);
    level(8'h00, 8'h00, 8'h30, 2'b00);
    access(1'b1, MODE_CONTROL_OFFSET, 8'h02);
    level(8'h00, 8'h00, 8'h10, 2'b01);
    rd(DETECT_SOURCE_OFFSET, 8'h09);
    level(8'h40, 8'h00, 8'h10, 2'b00);
    level(8'h08, 8'h00, 8'h10, 2'b00);
    level(8'h01, 8'h01, 8'h10, 2'b00);
    level(8'h09, 8'h01, 8'h10, 2'b10);
    tally_and_finish();
  end
  initial
  begin
    #200000;
    mismatches++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
